// [rtl/tbid_regs.vh]
`ifndef TBID_REGS_VH
`define TBID_REGS_VH
// Instruction word and field layout.
`define TBID_IW 12
`define TBID_F_LSB 0
`define TBID_F_MSB 4
`define TBID_D_POS 5
`define TBID_B_LSB 5
`define TBID_B_MSB 7
`define TBID_K_MSB 7
`define TBID_K9_MSB 8
`define TBID_DIR_FILE 3'h6
// Cadence: phases per instruction cycle.
`define TBID_PHASES 3'h4
`define TBID_PH_LAST 2'h3
// Reset values.
`define TBID_NOP_WORD 12'h000
`define TBID_DIR_RST 8'hff
// Operation codes driven to the datapath.
`define TBID_OP_NOP 5'h00
`define TBID_OP_MOVWF 5'h01
`define TBID_OP_CLR 5'h02
`define TBID_OP_SUBWF 5'h03
`define TBID_OP_DECF 5'h04
`define TBID_OP_IORWF 5'h05
`define TBID_OP_ANDWF 5'h06
`define TBID_OP_XORWF 5'h07
`define TBID_OP_ADDWF 5'h08
`define TBID_OP_MOVF 5'h09
`define TBID_OP_COMF 5'h0a
`define TBID_OP_INCF 5'h0b
`define TBID_OP_DECFSZ 5'h0c
`define TBID_OP_RRF 5'h0d
`define TBID_OP_RLF 5'h0e
`define TBID_OP_SWAPF 5'h0f
`define TBID_OP_INCFSZ 5'h10
`define TBID_OP_BCF 5'h11
`define TBID_OP_BSF 5'h12
`define TBID_OP_BTFSC 5'h13
`define TBID_OP_BTFSS 5'h14
`define TBID_OP_OPTION 5'h15
`define TBID_OP_SLEEP 5'h16
`define TBID_OP_CLRWDT 5'h17
`define TBID_OP_DIRLOAD 5'h18
`define TBID_OP_MOVLB 5'h19
`define TBID_OP_RETLW 5'h1a
`define TBID_OP_CALL 5'h1b
`define TBID_OP_JUMP 5'h1c
`define TBID_OP_MOVLW 5'h1d
`define TBID_OP_IORLW 5'h1e
`define TBID_OP_ANDLW 5'h1f
`define TBID_OP_XORLW 5'h0f
// Classes.
`define TBID_CL_BYTE 2'h0
`define TBID_CL_BIT 2'h1
`define TBID_CL_LIT 2'h2
`define TBID_CL_ILL 2'h3
`endif

// [rtl/tbid_field_split.v]
`timescale 1ns/1ps
`default_nettype none
`include "tbid_regs.vh"
// Pure combinational split of one instruction word into its classes and operands.
module tbid_field_split (
  input wire [11:0] instr,
  output reg [1:0] op_class,
  output reg [4:0] op_code,
  output reg op_xor_lit,
  output wire [4:0] file_sel,
  output wire dest_file,
  output wire [2:0] bit_pos,
  output reg [8:0] literal,
  output reg lit_wide
);
  assign file_sel = instr[`TBID_F_MSB:`TBID_F_LSB];
  assign dest_file = instr[`TBID_D_POS];
  assign bit_pos = instr[`TBID_B_MSB:`TBID_B_LSB];

  always @* begin
    op_class = `TBID_CL_LIT;
    op_code = `TBID_OP_NOP;
    op_xor_lit = 1'b0;
    literal = 9'h000;
    lit_wide = 1'b0;
    case (instr[11:10])
      2'h0: begin
        op_class = `TBID_CL_BYTE;
        case (instr[9:6])
          4'h0: begin
            op_class = `TBID_CL_LIT;
            if (instr[5] == 1'b1) begin
              op_class = `TBID_CL_BYTE;
              op_code = `TBID_OP_MOVWF;
            end else if (instr[4:3] == 2'h0) begin
              case (instr[2:0])
                3'h0: op_code = `TBID_OP_NOP;
                3'h2: op_code = `TBID_OP_OPTION;
                3'h3: op_code = `TBID_OP_SLEEP;
                3'h4: op_code = `TBID_OP_CLRWDT;
                default: op_code = `TBID_OP_DIRLOAD;
              endcase
              if (instr[2:0] == 3'h1 || instr[2:0] > 3'h4) begin
                op_code = `TBID_OP_DIRLOAD;
              end
            end else if (instr[4:3] == 2'h2) begin
              op_code = `TBID_OP_MOVLB;
              literal = {6'h00, instr[2:0]};
            end else begin
              op_class = `TBID_CL_ILL;
            end
          end
          4'h1: op_code = `TBID_OP_CLR;
          4'h2: op_code = `TBID_OP_SUBWF;
          4'h3: op_code = `TBID_OP_DECF;
          4'h4: op_code = `TBID_OP_IORWF;
          4'h5: op_code = `TBID_OP_ANDWF;
          4'h6: op_code = `TBID_OP_XORWF;
          4'h7: op_code = `TBID_OP_ADDWF;
          4'h8: op_code = `TBID_OP_MOVF;
          4'h9: op_code = `TBID_OP_COMF;
          4'ha: op_code = `TBID_OP_INCF;
          4'hb: op_code = `TBID_OP_DECFSZ;
          4'hc: op_code = `TBID_OP_RRF;
          4'hd: op_code = `TBID_OP_RLF;
          4'he: op_code = `TBID_OP_SWAPF;
          default: op_code = `TBID_OP_INCFSZ;
        endcase
      end
      2'h1: begin
        op_class = `TBID_CL_BIT;
        case (instr[9:8])
          2'h0: op_code = `TBID_OP_BCF;
          2'h1: op_code = `TBID_OP_BSF;
          2'h2: op_code = `TBID_OP_BTFSC;
          default: op_code = `TBID_OP_BTFSS;
        endcase
      end
      2'h2: begin
        literal = {1'b0, instr[`TBID_K_MSB:0]};
        case (instr[9:8])
          2'h0: op_code = `TBID_OP_RETLW;
          2'h1: op_code = `TBID_OP_CALL;
          default: begin
            op_code = `TBID_OP_JUMP;
            literal = instr[`TBID_K9_MSB:0];
            lit_wide = 1'b1;
          end
        endcase
      end
      default: begin
        literal = {1'b0, instr[`TBID_K_MSB:0]};
        case (instr[9:8])
          2'h0: op_code = `TBID_OP_MOVLW;
          2'h1: op_code = `TBID_OP_IORLW;
          2'h2: op_code = `TBID_OP_ANDLW;
          default: begin
            op_code = `TBID_OP_XORLW;
            op_xor_lit = 1'b1;
          end
        endcase
      end
    endcase
  end
endmodule // tbid_field_split
`default_nettype wire

// [rtl/tbid_decoder.v]
`timescale 1ns/1ps
`default_nettype none
`include "tbid_regs.vh"
module tbid_decoder (
  input wire sys_clk,
  input wire rst,
  input wire [11:0] fetch_word,
  input wire skip_cond,
  input wire pc_written,
  input wire [7:0] acc_value,
  output reg [1:0] phase_q,
  output reg fetch_strobe_q,
  output reg exec_strobe_q,
  output reg [1:0] op_class_q,
  output reg [4:0] op_code_q,
  output reg op_xor_lit_q,
  output reg [6:0] file_sel_q,
  output reg wr_acc_q,
  output reg wr_file_q,
  output reg [2:0] bit_pos_q,
  output reg [8:0] literal_q,
  output reg pc_load_q,
  output reg pc_bit9_force_zero_q,
  output reg port_read_pins_q,
  output reg [7:0] pin_direction_q,
  output reg idle_cycle_q
);
  reg [11:0] instr_q;
  reg flush_q;
  wire [1:0] cls;
  wire [4:0] opc;
  wire xl;
  wire [4:0] fsel;
  wire dsel;
  wire [2:0] bpos;
  wire [8:0] lit;
  wire lwide;
  wire last_phase;
  wire is_branch;
  wire is_test;
  wire writes_file;
  reg [11:0] instr_d;

  assign last_phase = (phase_q == `TBID_PH_LAST);

  // The word is latched at the end of a cycle; a flushed word becomes a no-op.
  always @* begin
    instr_d = instr_q;
    if (last_phase) begin
      instr_d = fetch_word;
    end
  end

  tbid_field_split u_split (
    .instr(instr_q),
    .op_class(cls),
    .op_code(opc),
    .op_xor_lit(xl),
    .file_sel(fsel),
    .dest_file(dsel),
    .bit_pos(bpos),
    .literal(lit),
    .lit_wide(lwide)
  );

  assign is_branch = (opc == `TBID_OP_CALL) || (opc == `TBID_OP_JUMP) ||
    (opc == `TBID_OP_RETLW);
  assign is_test = (opc == `TBID_OP_DECFSZ) || (opc == `TBID_OP_INCFSZ) ||
    (opc == `TBID_OP_BTFSC) || (opc == `TBID_OP_BTFSS);
  assign writes_file = (cls == `TBID_CL_BIT && !is_test) ||
    (cls == `TBID_CL_BYTE && (dsel || opc == `TBID_OP_MOVWF));

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 2'h0;
      fetch_strobe_q <= 1'b0;
      exec_strobe_q <= 1'b0;
      instr_q <= `TBID_NOP_WORD;
      flush_q <= 1'b1;
      op_class_q <= `TBID_CL_LIT;
      op_code_q <= `TBID_OP_NOP;
      op_xor_lit_q <= 1'b0;
      file_sel_q <= 7'h00;
      wr_acc_q <= 1'b0;
      wr_file_q <= 1'b0;
      bit_pos_q <= 3'h0;
      literal_q <= 9'h000;
      pc_load_q <= 1'b0;
      pc_bit9_force_zero_q <= 1'b0;
      port_read_pins_q <= 1'b0;
      pin_direction_q <= `TBID_DIR_RST;
      idle_cycle_q <= 1'b1;
    end else begin
      phase_q <= phase_q + 2'h1;
      fetch_strobe_q <= last_phase;
      exec_strobe_q <= (phase_q == 2'h2) && !flush_q;
      instr_q <= instr_d;
      if (last_phase) begin
        // Skip or branch resolved in this cycle discards the word just fetched.
        flush_q <= (!flush_q) && ((is_test && skip_cond) || is_branch ||
          (pc_written && writes_file));
        // A file write reaches the counter only once the datapath reports it at cycle end.
        if (!flush_q && pc_written && writes_file) begin
          pc_bit9_force_zero_q <= 1'b1;
        end
      end
      if (phase_q == 2'h0) begin
        idle_cycle_q <= flush_q;
        op_class_q <= flush_q ? `TBID_CL_LIT : cls;
        op_code_q <= flush_q ? `TBID_OP_NOP : opc;
        op_xor_lit_q <= xl && !flush_q;
        file_sel_q <= {2'h0, fsel};
        bit_pos_q <= bpos;
        literal_q <= lwide ? lit : {1'b0, lit[7:0]};
        wr_acc_q <= !flush_q && ((cls == `TBID_CL_BYTE && !dsel && opc != `TBID_OP_MOVWF) ||
          (cls == `TBID_CL_LIT && (opc == `TBID_OP_MOVLW || opc == `TBID_OP_IORLW ||
          opc == `TBID_OP_ANDLW || opc == `TBID_OP_RETLW || xl)));
        wr_file_q <= !flush_q && writes_file;
        pc_load_q <= !flush_q && is_branch;
        pc_bit9_force_zero_q <= !flush_q && (opc == `TBID_OP_CALL || opc == `TBID_OP_RETLW);
        // Read-modify-write of a port must see the pins; latch values would mask inputs.
        port_read_pins_q <= !flush_q && (cls != `TBID_CL_LIT);
        if (!flush_q && opc == `TBID_OP_DIRLOAD && instr_q[2:0] == `TBID_DIR_FILE) begin
          pin_direction_q <= acc_value;
        end
      end
    end
  end
endmodule // tbid_decoder
`default_nettype wire

// [verification/tbid_decoder_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tbid_regs.vh"
module tbid_decoder_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] fetch_word,
  input wire logic skip_cond,
  input wire logic pc_written,
  input wire logic [7:0] acc_value,
  input wire logic [1:0] phase_q,
  input wire logic fetch_strobe_q,
  input wire logic exec_strobe_q,
  input wire logic [4:0] op_code_q,
  input wire logic wr_acc_q,
  input wire logic wr_file_q,
  input wire logic [6:0] file_sel_q,
  input wire logic [2:0] bit_pos_q,
  input wire logic [8:0] literal_q,
  input wire logic pc_load_q,
  input wire logic pc_bit9_force_zero_q,
  input wire logic [7:0] pin_direction_q,
  input wire logic idle_cycle_q
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Only a capture that no skip or branch flushes decodes as written.
  logic clean;
  assign clean = phase_q == 2'h3 && !skip_cond && !pc_written && !pc_load_q;
  a_phase_step: assert property (!rst |=> phase_q == $past(phase_q) + 2'h1)
    else $error("phase skipped");
  a_fetch_pulse: assert property (phase_q == 2'h3 |=> fetch_strobe_q && phase_q == 2'h0)
    else $error("no fetch pulse");
  a_byte_dest: assert property (clean && fetch_word[11:10] == 2'h0 && fetch_word[9:6] != 4'h0
    |=> ##1 wr_file_q == $past(fetch_word[5], 2) && wr_acc_q != $past(fetch_word[5], 2))
    else $error("bad destination");
  a_bit_fields: assert property (clean && fetch_word[11:10] == 2'h1 |=> ##1
    file_sel_q == {2'h0, $past(fetch_word[4:0], 2)} && bit_pos_q == $past(fetch_word[7:5], 2))
    else $error("bad bit fields");
  a_jump_lit: assert property (clean && fetch_word[11:9] == 3'h5 |=> ##1
    literal_q == $past(fetch_word[8:0], 2) && pc_load_q && !pc_bit9_force_zero_q)
    else $error("bad jump");
  a_branch_idle: assert property (phase_q == 2'h3 && pc_load_q |=> ##1
    idle_cycle_q && op_code_q == `TBID_OP_NOP) else $error("branch not flushed");
  a_skip_idle: assert property (phase_q == 2'h3 && skip_cond && !idle_cycle_q &&
    (op_code_q == `TBID_OP_DECFSZ || op_code_q == `TBID_OP_INCFSZ ||
    op_code_q == `TBID_OP_BTFSC || op_code_q == `TBID_OP_BTFSS) |=> ##1 idle_cycle_q [*4])
    else $error("skip not flushed");
  a_exec_strobe: assert property (exec_strobe_q == (phase_q == 2'h3 && !idle_cycle_q))
    else $error("bad execute strobe");
  a_pc_file_zero: assert property (phase_q == 2'h3 && pc_written && wr_file_q &&
    !idle_cycle_q |=> pc_bit9_force_zero_q) else $error("ninth bit not cleared");
  a_dir_load: assert property (!$stable(pin_direction_q) |->
    pin_direction_q == $past(acc_value) && $past(phase_q) == 2'h0) else $error("bad direction");
endmodule // tbid_decoder_sva
`default_nettype wire

// [verification/tbid_fetch_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tbid_fetch_model (
  input wire logic [1:0] phase_q,
  input wire logic [11:0] next_word,
  output logic [11:0] fetch_word
);
  // Off the capture phase the bus shows the inverted word, so an early or late sample is caught.
  assign fetch_word = (phase_q == 2'h3) ? next_word : ~next_word;
endmodule // tbid_fetch_model
`default_nettype wire

// [verification/tbid_decoder_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tbid_regs.vh"
module tbid_decoder_bench;
  typedef struct packed {
    logic [11:0] w;
    logic [1:0] sp;
    logic [1:0] c;
    logic [4:0] o;
    logic [2:0] ilz;
    logic [8:0] v;
  } tbid_row_t;
  localparam tbid_row_t rows [14] = '{
    '{12'h1e5, 2'h0, `TBID_CL_BYTE, `TBID_OP_ADDWF, 3'h0, 9'h085},
    '{12'h1df, 2'h0, `TBID_CL_BYTE, `TBID_OP_ADDWF, 3'h0, 9'h11f},
    '{12'h5e3, 2'h0, `TBID_CL_BIT, `TBID_OP_BSF, 3'h0, 9'h0e3},
    '{12'hca5, 2'h0, `TBID_CL_LIT, `TBID_OP_MOVLW, 3'h0, 9'h0a5},
    '{12'hf3c, 2'h0, `TBID_CL_LIT, `TBID_OP_XORLW, 3'h0, 9'h03c},
    '{12'hbab, 2'h0, `TBID_CL_LIT, `TBID_OP_JUMP, 3'h2, 9'h1ab},
    '{12'hc11, 2'h0, 2'h0, `TBID_OP_NOP, 3'h4, 9'h000},
    '{12'h942, 2'h0, `TBID_CL_LIT, `TBID_OP_CALL, 3'h3, 9'h042},
    '{12'hc11, 2'h0, 2'h0, `TBID_OP_NOP, 3'h4, 9'h000},
    '{12'h2a2, 2'h0, `TBID_CL_BYTE, `TBID_OP_INCF, 3'h0, 9'h082},
    '{12'h2e2, 2'h2, `TBID_CL_BYTE, `TBID_OP_DECFSZ, 3'h0, 9'h082},
    '{12'hc11, 2'h2, 2'h0, `TBID_OP_NOP, 3'h4, 9'h000},
    '{12'h022, 2'h0, `TBID_CL_BYTE, `TBID_OP_MOVWF, 3'h0, 9'h082},
    '{12'hc11, 2'h1, 2'h0, `TBID_OP_NOP, 3'h4, 9'h000}
  };
  logic sys_clk, rst, skip_cond, pc_written, fetch_strobe_q, exec_strobe_q, op_xor_lit_q;
  logic wr_acc_q, wr_file_q, pc_load_q, pc_bit9_force_zero_q, port_read_pins_q, idle_cycle_q;
  logic [1:0] phase_q, op_class_q;
  logic [2:0] bit_pos_q;
  logic [4:0] op_code_q;
  logic [6:0] file_sel_q;
  logic [7:0] acc_value, pin_direction_q;
  logic [8:0] literal_q;
  logic [11:0] next_word, fetch_word;
  integer n_errors, tests_run, r;
  tbid_decoder tbid_decoder_i (.sys_clk, .rst, .fetch_word, .skip_cond, .pc_written, .acc_value,
    .phase_q, .fetch_strobe_q, .exec_strobe_q, .op_class_q, .op_code_q, .op_xor_lit_q,
    .file_sel_q, .wr_acc_q, .wr_file_q, .bit_pos_q, .literal_q, .pc_load_q,
    .pc_bit9_force_zero_q, .port_read_pins_q, .pin_direction_q, .idle_cycle_q);
  tbid_fetch_model tbid_fetch_model_i (.phase_q, .next_word, .fetch_word);
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task complete_run;
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Presents one word through phase 3 and returns once its decode has landed.
  task issue(input logic [11:0] w, input logic [1:0] sp, input logic [7:0] a);
    integer k;
    k = 0;
    while (phase_q !== 2'h2 && k < 8) begin
      @(negedge sys_clk);
      k = k + 1;
    end
    if (k == 8) begin
      check(16'h0001, 16'h0000);
      complete_run;
    end
    @(posedge sys_clk);
    next_word <= w;
    {skip_cond, pc_written} <= sp;
    acc_value <= a;
    @(posedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  function automatic logic [8:0] opnd(input logic [1:0] c);
    if (c == `TBID_CL_BYTE) return {wr_acc_q, wr_file_q, file_sel_q};
    if (c == `TBID_CL_BIT) return {1'h0, bit_pos_q, file_sel_q[4:0]};
    return literal_q;
  endfunction
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'h1;
    skip_cond = 1'h0;
    pc_written = 1'h0;
    acc_value = 8'h00;
    next_word = 12'h000;
    n_errors = 0;
    tests_run = 0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check({phase_q, idle_cycle_q, pin_direction_q}, {2'h0, 1'h1, `TBID_DIR_RST});
    @(posedge sys_clk);
    rst <= 1'h0;
    issue(12'h000, 2'h0, 8'h00);
    for (r = 0; r < 14; r = r + 1) begin
      issue(rows[r].w, rows[r].sp, 8'h00);
      check({op_code_q, idle_cycle_q, pc_load_q}, {rows[r].o, rows[r].ilz[2:1]});
      check(op_xor_lit_q, !rows[r].ilz[2] && rows[r].w[11:8] == 4'hf);
      check(port_read_pins_q, !rows[r].ilz[2] && rows[r].c != `TBID_CL_LIT);
      if (!rows[r].ilz[2]) begin
        check(op_class_q, rows[r].c);
        check({pc_bit9_force_zero_q, opnd(rows[r].c)}, {rows[r].ilz[0], rows[r].v});
      end
    end
    // Only register number six reaches the direction latches.
    issue(12'h006, 2'h0, 8'h5a);
    issue(12'h000, 2'h0, 8'h5a);
    check(pin_direction_q, 8'h5a);
    issue(12'h005, 2'h0, 8'h00);
    issue(12'h000, 2'h0, 8'h00);
    check(pin_direction_q, 8'h5a);
    @(posedge sys_clk);
    rst <= 1'h1;
    @(negedge sys_clk);
    check({phase_q, idle_cycle_q, pin_direction_q}, {2'h0, 1'h1, `TBID_DIR_RST});
    @(posedge sys_clk);
    rst <= 1'h0;
    issue(12'h1e5, 2'h0, 8'h00);
    check(wr_file_q, 1'h1);
    complete_run;
  end
endmodule // tbid_decoder_bench
bind tbid_decoder tbid_decoder_sva tbid_decoder_sva_i (.sys_clk, .rst, .fetch_word, .skip_cond,
  .pc_written, .acc_value, .phase_q, .fetch_strobe_q, .op_code_q, .wr_acc_q, .wr_file_q,
  .exec_strobe_q, .file_sel_q, .bit_pos_q, .literal_q, .pc_load_q, .pc_bit9_force_zero_q,
  .pin_direction_q, .idle_cycle_q);
`default_nettype wire
